//--- bench/smf_monitor_sva.sv
// checker: concurrent assertions on the supply monitor ports
module smf_monitor_sva
	import smf_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// register bus
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	// comparators, interrupt and watchdog
	input wire logic       digital_cmp_raw,
	input wire logic [1:0] digital_trip_sel,
	input wire logic [1:0] analog_trip_sel,
	input wire logic       comparators_on,
	input wire logic       secondary_interrupt_enable_priority,
	input wire logic       low_supply_irq,
	input wire logic       watchdog_enable_clr
);
	logic wr_hit;
	logic rd_hit;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// decoded accesses to the control register
	assign wr_hit = sfr_wr && sfr_addr == SMF_CTRL_ADDR;
	assign rd_hit = sfr_rd && sfr_addr == SMF_CTRL_ADDR;
	a_access_hit: assert property ((wr_hit || rd_hit) |=> sfr_hit)
		else $error("no hit after a control access");
	a_unmapped_quiet: assert property (sfr_rd && !rd_hit && !wr_hit |=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("unmapped read answered");
	a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	a_enable_copy: assert property (wr_hit |=> comparators_on == $past(sfr_wdata[SMF_BIT_EN]))
		else $error("enable not taken from write");
	a_trip_copy: assert property (wr_hit |=> {digital_trip_sel, analog_trip_sel} == $past(sfr_wdata[4:1]))
		else $error("trip selects not taken from write");
	a_irq_gate: assert property (!secondary_interrupt_enable_priority |=> !low_supply_irq)
		else $error("interrupt while core enable clear");
	a_wd_pulse: assert property (watchdog_enable_clr == $rose(low_supply_irq))
		else $error("watchdog clear not tied to interrupt rise");
	// flag cannot drop while the digital supply is low and monitored
	a_flag_hold: assert property (low_supply_irq && secondary_interrupt_enable_priority && comparators_on
		&& !sfr_wr && !digital_cmp_raw |=> low_supply_irq)
		else $error("flag dropped during low supply");
endmodule : smf_monitor_sva

bind smf_supply_monitor smf_monitor_sva u_sva (.clk(clk), .nrst(nrst), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
	.sfr_hit(sfr_hit), .digital_cmp_raw(digital_cmp_raw), .digital_trip_sel(digital_trip_sel),
	.analog_trip_sel(analog_trip_sel), .comparators_on(comparators_on),
	.secondary_interrupt_enable_priority(secondary_interrupt_enable_priority),
	.low_supply_irq(low_supply_irq), .watchdog_enable_clr(watchdog_enable_clr));

//--- bench/smf_supply_model.sv
// partner model: supply comparators and a sped-up timebase
module smf_supply_model (
	// clock
	input  wire logic        clk,
	// supply levels in millivolts and trip selects
	input  wire logic [15:0] digital_mv,
	input  wire logic [15:0] analog_mv,
	input  wire logic [1:0]  digital_trip_sel,
	input  wire logic [1:0]  analog_trip_sel,
	// comparator outputs and timebase
	output logic             digital_cmp_raw,
	output logic             analog_cmp_raw,
	output logic             timebase_32k
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] tb_cnt_q = 2'h0;
	// trip level per code
	function automatic int trip(input logic [1:0] c);
		return c == 2'h0 ? 4630 : c == 2'h1 ? 3080 : c == 2'h2 ? 2930 : 2630;
	endfunction : trip
	// high while the supply sits above its trip level
	assign digital_cmp_raw = digital_mv > trip(digital_trip_sel);
	assign analog_cmp_raw  = analog_mv > trip(analog_trip_sel);
	// runs free, one period per four core cycles to keep the hold-off short
	always @(posedge clk) begin
		tb_cnt_q <= tb_cnt_q + 2'h1;
	end
	assign timebase_32k = tb_cnt_q[1];
endmodule : smf_supply_model

//--- bench/smf_testbench.sv
// testbench: register, threshold, filter and hold-off checks of the supply monitor
module testbench
	import smf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        ie = 1'b0;
	logic [15:0] vd = 16'h1388;
	logic [15:0] va = 16'h1388;
	logic [7:0]  rdata;
	logic [1:0]  dsel, asel;
	logic        hit, dcmp, acmp, on, irq, wdc, tbase;
	int          failures = 0;
	int          total_checks = 0;
	int          seed = 49;
	int          wd_pulses = 0;
	int          wd_base = 0;
	int          en = 0, dth = 3, ath = 3, flag = 0; // reference register state
	always #2 clk = ~clk;
	smf_supply_monitor u_dut (.clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
		.sfr_wdata(wdata), .sfr_rdata(rdata), .sfr_hit(hit), .digital_cmp_raw(dcmp),
		.analog_cmp_raw(acmp), .digital_trip_sel(dsel), .analog_trip_sel(asel),
		.comparators_on(on), .timebase_32k(tbase), .secondary_interrupt_enable_priority(ie),
		.low_supply_irq(irq), .watchdog_enable_clr(wdc));
	smf_supply_model u_model (.clk(clk), .digital_mv(vd), .analog_mv(va), .digital_trip_sel(dsel),
		.analog_trip_sel(asel), .digital_cmp_raw(dcmp), .analog_cmp_raw(acmp), .timebase_32k(tbase));
	// watchdog clear pulses, counted so a scenario can compare the tally
	always @(posedge clk) begin
		if (wdc === 1'b1) begin
			wd_pulses++;
		end
	end
	function automatic int trip(input logic [1:0] c);
		return c == 2'h0 ? 4630 : c == 2'h1 ? 3080 : c == 2'h2 ? 2930 : 2630;
	endfunction : trip
	// expected register view; a disabled monitor reads both supplies as good
	function automatic logic [7:0] view();
		logic dok, aok;
		dok = en == 0 || vd > trip(dth[1:0]);
		aok = en == 0 || va > trip(ath[1:0]);
		return {dok, aok, flag[0], dth[1:0], ath[1:0], en[0]};
	endfunction : view
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// one-cycle strobe, answer lands on the taking edge
	task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge clk) #1;
		addr = a;
		wr = w;
		rd = !w;
		wdata = d;
		@(posedge clk) #1;
		wr = 1'b0;
		rd = 1'b0;
	endtask : access
	task automatic expect_ctrl();
		access(SMF_CTRL_ADDR, 1'b0, 8'h00);
		check(rdata, view());
		check({7'h00, hit}, 8'h01);
		check({7'h00, irq}, {7'h00, flag[0] & ie});
	endtask : expect_ctrl
	task automatic summarize();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	initial begin
		#400000;
		failures++;
		summarize();
	end
	initial begin
		logic [7:0] w;
		repeat (5) @(posedge clk);
		#1 nrst = 1'b1;
		expect_ctrl();
		access(8'hDE, 1'b1, 8'hFF);
		access(8'hDE, 1'b0, 8'h00);
		check(rdata, 8'h00);
		check({7'h00, hit}, 8'h00);
		// random writes with good supplies; read-only bits ignored
		for (int i = 0; i < 8; i++) begin
			w = $random(seed);
			ie = w[7];
			access(SMF_CTRL_ADDR, 1'b1, w);
			en = w[0];
			dth = w[4:3];
			ath = w[2:1];
			flag = w[5];
			expect_ctrl();
			check({3'h0, dsel, asel, on}, {3'h0, w[4:0]});
		end
		ie = 1'b1;
		access(SMF_CTRL_ADDR, 1'b1, 8'h01);
		{en, dth, ath, flag} = {32'd1, 32'd0, 32'd0, 32'd0};
		// a dip shorter than the filter must not set the flag
		va = 16'h07D0;
		repeat (20) @(posedge clk);
		#1 va = 16'h1388;
		repeat (40) @(posedge clk);
		expect_ctrl();
		wd_base = wd_pulses;
		vd = 16'h0BB8;
		access(SMF_CTRL_ADDR, 1'b1, 8'h09);
		dth = 1;
		repeat (40) @(posedge clk);
		flag = 1;
		expect_ctrl();
		check(8'(wd_pulses - wd_base), 8'h01);
		access(SMF_CTRL_ADDR, 1'b1, 8'h09);
		expect_ctrl();
		// recovery, a second drop, then the full hold-off
		vd = 16'h1388;
		repeat (3000) @(posedge tbase);
		#1 vd = 16'h0BB8;
		repeat (40) @(posedge clk);
		#1 vd = 16'h1388;
		repeat (8172) @(posedge tbase);
		expect_ctrl();
		repeat (40) @(posedge tbase);
		flag = 0;
		expect_ctrl();
		access(SMF_CTRL_ADDR, 1'b1, 8'h08);
		en = 0;
		vd = 16'h07D0;
		repeat (40) @(posedge clk);
		expect_ctrl();
		summarize();
	end
endmodule : testbench

//--- core/smf_cmp_if.sv
// interface: filtered comparator levels between the filters and the control core
interface smf_cmp_if;
	logic raw;
	logic ok;
	modport filt (input raw, output ok);
	modport core (output raw, input ok);
endinterface : smf_cmp_if

//--- core/smf_glitch_filter.sv
// glitch filter: a comparator level is accepted after a run of equal samples
module smf_glitch_filter
	import smf_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// comparator path
	smf_cmp_if.filt   cmp
);
	typedef struct packed {
		logic                  ok;
		logic [SMF_FILT_W-1:0] cnt;
	} smf_filt_t;

	smf_filt_t s_q;
	smf_filt_t s_d;

	// count while raw differs from the accepted level; any agreement restarts
	always_comb begin
		s_d = s_q;
		if (cmp.raw == s_q.ok) begin
			s_d.cnt = SMF_FILT_ZERO;
		end else if (s_q.cnt == SMF_FILT_W'(SMF_FILT_CYC - 1)) begin
			s_d.ok  = cmp.raw;
			s_d.cnt = SMF_FILT_ZERO;
		end else begin
			s_d.cnt = s_q.cnt + SMF_FILT_W'(1);
		end
	end

	// resets to ok so a disabled monitor reads supplies as high
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{ok: 1'b1, cnt: SMF_FILT_ZERO};
		end else begin
			s_q <= s_d;
		end
	end

	assign cmp.ok = s_q.ok;
endmodule : smf_glitch_filter

//--- core/smf_pkg.sv
// package: constants and types for the supply monitor flag logic
package smf_pkg;
	// register address on the special-function-register bus, and the register's reset value
	localparam logic [7:0] SMF_CTRL_ADDR   = 8'hDF;
	localparam logic [7:0] SMF_CTRL_RESET  = 8'hDE;
	// bit positions inside the control register
	localparam int         SMF_BIT_DOK     = 7;
	localparam int         SMF_BIT_AOK     = 6;
	localparam int         SMF_BIT_FLAG    = 5;
	localparam int         SMF_BIT_DTH_HI  = 4;
	localparam int         SMF_BIT_DTH_LO  = 3;
	localparam int         SMF_BIT_ATH_HI  = 2;
	localparam int         SMF_BIT_ATH_LO  = 1;
	localparam int         SMF_BIT_EN      = 0;
	// threshold codes, millivolt trip levels
	localparam logic [1:0] SMF_TH_4P63     = 2'h0;
	localparam logic [1:0] SMF_TH_3P08     = 2'h1;
	localparam logic [1:0] SMF_TH_2P93     = 2'h2;
	localparam logic [1:0] SMF_TH_2P63     = 2'h3;
	localparam int         SMF_MV_4P63     = 4630;
	localparam int         SMF_MV_3P08     = 3080;
	localparam int         SMF_MV_2P93     = 2930;
	localparam int         SMF_MV_2P63     = 2630;
	// timing: core clock and the slow timebase
	localparam int         SMF_CLK_HZ      = 250_000_000;
	localparam int         SMF_TB_HZ       = 32768;
	localparam int         SMF_HOLD_MS     = 250;
	// hold-off in timebase ticks (longest time, rounded down)
	localparam int         SMF_HOLD_TICKS  = (SMF_TB_HZ * SMF_HOLD_MS) / 1000;
	localparam int         SMF_HOLD_W      = 14;
	// glitch filter: consecutive equal samples needed to accept a level
	localparam int         SMF_FILT_NS     = 100;
	localparam int         SMF_FILT_CYC    = (SMF_FILT_NS * (SMF_CLK_HZ / 1_000_000)) / 1000;
	localparam int         SMF_FILT_W      = 8;
	localparam logic [SMF_HOLD_W-1:0] SMF_HOLD_ZERO = 14'h0000;
	localparam logic [SMF_FILT_W-1:0] SMF_FILT_ZERO = 8'h00;

	// hold-off states
	typedef enum logic [1:0] {
		SMF_IDLE = 2'b00,
		SMF_LOW  = 2'b01,
		SMF_HOLD = 2'b10
	} smf_state_t;

	// trip level in millivolts for a threshold code
	function automatic int smf_trip_mv(input logic [1:0] code);
		case (code)
			SMF_TH_4P63: smf_trip_mv = SMF_MV_4P63;
			SMF_TH_3P08: smf_trip_mv = SMF_MV_3P08;
			SMF_TH_2P93: smf_trip_mv = SMF_MV_2P93;
			default:     smf_trip_mv = SMF_MV_2P63;
		endcase
	endfunction : smf_trip_mv
endpackage : smf_pkg

//--- core/smf_supply_monitor.sv
// top: supply monitor control register, low-supply flag and hold-off timer
//
// Contract
// - monitor active only while enable bit set
// - bits 7,6 read live comparator levels
// - either comparator low sets low-supply flag
// - both high for 250 ms clears flag
// - software clear ignored while supply low
// - digital threshold field bits 4:3 selects trip
// - analog threshold field bits 2:1 same encoding
// - interrupt only when core enable bit set
// - glitches filtered before setting the flag
// - control register resets to 0xDE
// - low-supply interrupt clears watchdog enable
module smf_supply_monitor
	import smf_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// special-function-register bus
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	output logic            sfr_hit,
	// analog comparators, high when the supply is above its trip level
	input  wire logic       digital_cmp_raw,
	input  wire logic       analog_cmp_raw,
	output logic      [1:0] digital_trip_sel,
	output logic      [1:0] analog_trip_sel,
	output logic            comparators_on,
	// always-running 32.768 kHz timebase, sampled level
	input  wire logic       timebase_32k,
	// core interrupt enable and request
	input  wire logic       secondary_interrupt_enable_priority,
	output logic            low_supply_irq,
	// watchdog enable clear request, one cycle
	output logic            watchdog_enable_clr
);
	import smf_pkg::*;

	typedef struct packed {
		logic            monitor_enable;
		logic [1:0]      digital_threshold;
		logic [1:0]      analog_threshold;
		logic            low_supply_flag;
		smf_state_t      state;
		logic [SMF_HOLD_W-1:0] hold_cnt;
		logic [7:0]      rdata;
		logic            hit;
		logic            irq;
		logic            wd_clr;
	} smf_top_t;

	smf_top_t   s_q;
	smf_top_t   s_d;
	smf_cmp_if  dig_if ();
	smf_cmp_if  ana_if ();
	logic       tb_tick;
	logic       digital_supply_ok;
	logic       analog_supply_ok;
	logic       any_low;
	logic       sel;
	logic [7:0] ctrl_view;

	// comparator inputs pass through the glitch filters
	assign dig_if.raw = digital_cmp_raw;
	assign ana_if.raw = analog_cmp_raw;

	smf_glitch_filter u_dig_filt (
		.clk  (clk),
		.nrst (nrst),
		.cmp  (dig_if.filt)
	);

	smf_glitch_filter u_ana_filt (
		.clk  (clk),
		.nrst (nrst),
		.cmp  (ana_if.filt)
	);

	smf_timebase u_tb (
		.clk      (clk),
		.nrst     (nrst),
		.tb_level (timebase_32k),
		.tb_tick  (tb_tick)
	);

	// disabled monitor reads both supplies high and never flags
	assign digital_supply_ok = dig_if.ok | ~s_q.monitor_enable;
	assign analog_supply_ok  = ana_if.ok | ~s_q.monitor_enable;
	assign any_low           = ~digital_supply_ok | ~analog_supply_ok;
	assign sel               = (sfr_addr == SMF_CTRL_ADDR);

	// register view with live comparator bits
	always_comb begin
		ctrl_view                 = 8'h00;
		ctrl_view[SMF_BIT_DOK]    = digital_supply_ok;
		ctrl_view[SMF_BIT_AOK]    = analog_supply_ok;
		ctrl_view[SMF_BIT_FLAG]   = s_q.low_supply_flag;
		ctrl_view[SMF_BIT_DTH_HI] = s_q.digital_threshold[1];
		ctrl_view[SMF_BIT_DTH_LO] = s_q.digital_threshold[0];
		ctrl_view[SMF_BIT_ATH_HI] = s_q.analog_threshold[1];
		ctrl_view[SMF_BIT_ATH_LO] = s_q.analog_threshold[0];
		ctrl_view[SMF_BIT_EN]     = s_q.monitor_enable;
	end

	// register writes, flag, hold-off sequencing and outputs
	always_comb begin
		s_d        = s_q;
		s_d.hit    = 1'b0;
		s_d.wd_clr = 1'b0;

		// bus: one-cycle read answer, unmapped addresses read zero
		if (sfr_rd && sel) begin
			s_d.rdata = ctrl_view;
			s_d.hit   = 1'b1;
		end else if (sfr_rd) begin
			s_d.rdata = 8'h00;
		end

		// control writes; comparator bits are read-only
		if (sfr_wr && sel) begin
			s_d.hit               = 1'b1;
			s_d.monitor_enable    = sfr_wdata[SMF_BIT_EN];
			s_d.digital_threshold = {sfr_wdata[SMF_BIT_DTH_HI], sfr_wdata[SMF_BIT_DTH_LO]};
			s_d.analog_threshold  = {sfr_wdata[SMF_BIT_ATH_HI], sfr_wdata[SMF_BIT_ATH_LO]};
			// a clear only lands while supplies are good; set always lands
			if (sfr_wdata[SMF_BIT_FLAG] || !any_low) begin
				s_d.low_supply_flag = sfr_wdata[SMF_BIT_FLAG];
			end
		end

		// hold-off sequencer; the hardware set overrides any write
		case (s_q.state)
			SMF_IDLE: begin
				if (any_low) begin
					s_d.state = SMF_LOW;
				end
			end
			SMF_LOW: begin
				if (!any_low) begin
					s_d.state    = SMF_HOLD;
					s_d.hold_cnt = SMF_HOLD_ZERO;
				end
			end
			SMF_HOLD: begin
				if (any_low) begin
					s_d.state = SMF_LOW;
				end else if (tb_tick) begin
					// ticks come from the slow timebase, not the core clock
					if (s_q.hold_cnt == SMF_HOLD_W'(SMF_HOLD_TICKS - 1)) begin
						s_d.state           = SMF_IDLE;
						s_d.low_supply_flag = 1'b0;
					end else begin
						s_d.hold_cnt = s_q.hold_cnt + SMF_HOLD_W'(1);
					end
				end
			end
			default: begin
				s_d.state = SMF_IDLE;
			end
		endcase

		if (any_low) begin
			s_d.low_supply_flag = 1'b1;
		end

		// interrupt gated by the core enable; watchdog stop on its rise
		s_d.irq    = s_d.low_supply_flag & secondary_interrupt_enable_priority;
		s_d.wd_clr = s_d.irq & ~s_q.irq;
	end

	// reset value of the control register is 0xDE
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q.monitor_enable    <= SMF_CTRL_RESET[SMF_BIT_EN];
			s_q.digital_threshold <= {SMF_CTRL_RESET[SMF_BIT_DTH_HI], SMF_CTRL_RESET[SMF_BIT_DTH_LO]};
			s_q.analog_threshold  <= {SMF_CTRL_RESET[SMF_BIT_ATH_HI], SMF_CTRL_RESET[SMF_BIT_ATH_LO]};
			s_q.low_supply_flag   <= SMF_CTRL_RESET[SMF_BIT_FLAG];
			s_q.state             <= SMF_IDLE;
			s_q.hold_cnt          <= SMF_HOLD_ZERO;
			s_q.rdata             <= 8'h00;
			s_q.hit               <= 1'b0;
			s_q.irq               <= 1'b0;
			s_q.wd_clr            <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flip-flops
	assign sfr_rdata           = s_q.rdata;
	assign sfr_hit             = s_q.hit;
	assign digital_trip_sel    = s_q.digital_threshold;
	assign analog_trip_sel     = s_q.analog_threshold;
	assign comparators_on      = s_q.monitor_enable;
	assign low_supply_irq      = s_q.irq;
	assign watchdog_enable_clr = s_q.wd_clr;
endmodule : smf_supply_monitor

//--- core/smf_timebase.sv
// timebase edge detector: one-cycle tick per rising edge of the slow clock
module smf_timebase
	import smf_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// slow timebase level in, tick out
	input  wire logic tb_level,
	output logic      tb_tick
);
	typedef struct packed {
		logic last;
		logic tick;
	} smf_tb_t;

	smf_tb_t s_q;
	smf_tb_t s_d;

	// timebase is sampled as synchronous; edge found against the last sample
	always_comb begin
		s_d      = s_q;
		s_d.last = tb_level;
		s_d.tick = tb_level & ~s_q.last;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{last: 1'b0, tick: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign tb_tick = s_q.tick;
endmodule : smf_timebase
